// *** event_counter.sv ***
/*
 * Free-running statistics counter, wraps at its width.
 * Assumes increments come from logic on the same clock.
 */
`default_nettype none

module event_counter #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [1:0]   inc,
    output logic      [W-1:0] count_q
);

    // reads are plain wire taps, so software never perturbs counting
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + W'(inc); // see R20
        end
    end

endmodule

`default_nettype wire

// *** gfp_error_stats_threshold_monitor.sv ***
/*
 * GFP / 8b10b error statistics with threshold alarms, AXI4-Lite slave.
 * Assumes all event inputs are one-cycle pulses (in_frame a level)
 * from receive-path logic on clk; no synchronisers are needed.
 */
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none

module gfp_error_stats_threshold_monitor #(
    parameter int SEC_CYCLES_P = gfp_stats_pkg::SEC_CYCLES
) (
    input  wire logic                            clk,
    input  wire logic                            rst_b,
    input  wire logic                            rx_lcv_pulse,
    input  wire logic                            tx_lcv_pulse,
    input  wire logic                            fc_rx_lcv_pulse,
    input  wire logic                            payload_crc_fail,
    input  wire logic                            superblock_crc_fail,
    input  wire logic                            csf_frame,
    input  wire logic                            in_frame,
    input  wire logic                            core_hdr_uncorr,
    input  wire logic                            type_hdr_uncorr,
    output logic [gfp_stats_pkg::NUM_MON-1:0]    rise_event_q,
    output logic [gfp_stats_pkg::NUM_MON-1:0]    fall_event_q,
    input  wire logic [gfp_stats_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                            awvalid,
    output logic                                 awready,
    input  wire logic [31:0]                     wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    output logic [1:0]                           bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    input  wire logic [gfp_stats_pkg::ADDR_W-1:0] araddr,
    input  wire logic                            arvalid,
    output logic                                 arready,
    output logic [31:0]                          rdata,
    output logic [1:0]                           rresp,
    output logic                                 rvalid,
    input  wire logic                            rready
);
    import gfp_stats_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ------------
    // event qualification and counters
    // ------------
    logic             in_frame_q;
    logic [1:0]       inc     [NUM_CNT];
    logic [CNT_W-1:0] cnt     [NUM_CNT];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= in_frame;
        end
    end

    // cbr and low-rate fc violations may coincide: both counted
    assign inc[IDX_RX_LCV] = {1'b0, rx_lcv_pulse}
                           + {1'b0, fc_rx_lcv_pulse}; // see R1, R19
    assign inc[IDX_TX_LCV] = {1'b0, tx_lcv_pulse}; // see R2
    assign inc[IDX_PL_CRC] = {1'b0, payload_crc_fail}; // see R3
    assign inc[IDX_SB_CRC] = {1'b0, superblock_crc_fail}; // see R4
    assign inc[IDX_CSF]    = {1'b0, csf_frame}; // see R5
    // only a loss while in frame counts, not a stay out of frame
    assign inc[IDX_LFD]    = {1'b0, in_frame_q & ~in_frame}; // see R6
    assign inc[IDX_CHEC]   = {1'b0, core_hdr_uncorr}; // see R7
    assign inc[IDX_THEC]   = {1'b0, type_hdr_uncorr}; // see R8

    for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
        event_counter #(.W(CNT_W)) u_cnt (
            .clk     (clk),
            .rst_b   (rst_b),
            .inc     (inc[c]),
            .count_q (cnt[c])
        );
    end

    // ------------
    // seconds tick
    // ------------
    logic [31:0] tick_cnt_q;
    logic        sec_tick_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= '0;
            sec_tick_q <= 1'b0;
        end else if (tick_cnt_q >= 32'(SEC_CYCLES_P - 1)) begin
            tick_cnt_q <= '0;
            sec_tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            sec_tick_q <= 1'b0;
        end
    end

    // ------------
    // configuration storage
    // ------------
    logic             trunk_q;
    logic [2:0]       mctrl_q    [NUM_MON];
    logic [CNT_W-1:0] period_q   [NUM_MON];
    logic [CNT_W-1:0] rise_q     [NUM_MON];
    logic [CNT_W-1:0] fall_q     [NUM_MON];
    logic [CNT_W-1:0] t_rise_q   [NUM_MON];
    logic [CNT_W-1:0] t_fall_q   [NUM_MON];
    logic [31:0]      evt_q;
    logic [NUM_MON-1:0] armed;

    // ------------
    // monitors: index = 2*counter + interval (0 15-min, 1 1-day)
    // ------------
    for (genvar m = 0; m < NUM_MON; m++) begin : g_mon
        logic [CNT_W-1:0] r_thr;
        logic [CNT_W-1:0] f_thr;
        // trunk bank replaces the client bank when selected
        assign r_thr = trunk_q ? t_rise_q[m] : rise_q[m]; // see R18
        assign f_thr = trunk_q ? t_fall_q[m] : fall_q[m]; // see R18
        threshold_monitor #(.W(CNT_W)) u_mon (
            .clk          (clk),
            .rst_b        (rst_b),
            .total        (cnt[m/2]),
            .inc          (inc[m/2]),
            .sec_tick     (sec_tick_q),
            .alarm_type   (mctrl_q[m][MCTRL_TYPE_LSB +: 2]),
            .abs_mode     (mctrl_q[m][MCTRL_ABS_BIT]),
            .period       (period_q[m]),
            .rise_thr     (r_thr),
            .fall_thr     (f_thr),
            .rise_evt_q   (rise_event_q[m]),
            .fall_evt_q   (fall_event_q[m]),
            .rise_armed_q (armed[m])
        );
    end

    // ------------
    // axi write channel
    // ------------
    logic              aw_have_q;
    logic              w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              wr_fire;

    assign awready = ~aw_have_q & ~bvalid;
    assign wready  = ~w_have_q & ~bvalid;
    assign wr_fire = aw_have_q & w_have_q & ~bvalid;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write decode
    logic       wr_ctrl, wr_evt, wr_mon, wr_trunk, wr_ro;
    logic [3:0] wr_idx_m, wr_idx_t;

    always_comb begin
        wr_ctrl  = aw_addr_q[11:2] == ADDR_CTRL[11:2];
        wr_evt   = aw_addr_q[11:2] == ADDR_EVT[11:2];
        wr_ro    = (aw_addr_q[11:2] == ADDR_ARM[11:2])
                 | (aw_addr_q[11:5] == ADDR_CNT_BASE[11:5]);
        wr_mon   = aw_addr_q[11:8] == ADDR_MON_BASE[11:8];
        wr_trunk = aw_addr_q[11:7] == ADDR_TRUNK_BASE[11:7];
        wr_idx_m = aw_addr_q[7:4];
        wr_idx_t = aw_addr_q[6:3];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= (wr_ctrl | wr_evt | wr_ro | wr_mon | wr_trunk)
                    ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------
    // register updates
    // ------------
    logic [31:0] ctrl_new;
    assign ctrl_new = merge({31'h0, trunk_q}, w_data_q, w_strb_q);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trunk_q <= 1'b0;
        end else if (wr_fire && wr_ctrl) begin
            trunk_q <= ctrl_new[CTRL_TRUNK_BIT];
        end
    end

    // per-interval sets live at distinct monitor indices
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int m = 0; m < NUM_MON; m++) begin
                mctrl_q[m]  <= MCTRL_RST;
                period_q[m] <= PERIOD_RST;
                rise_q[m]   <= RISE_RST;
                fall_q[m]   <= FALL_RST;
            end
        end else if (wr_fire && wr_mon) begin
            case (aw_addr_q[3:2]) // see R17, R12
                MON_CTRL_OFS: begin
                    mctrl_q[wr_idx_m] <= 3'(merge({29'h0, mctrl_q[wr_idx_m]},
                                                  w_data_q, w_strb_q));
                end
                MON_PERIOD_OFS: begin
                    period_q[wr_idx_m] <= merge(period_q[wr_idx_m],
                                                w_data_q, w_strb_q);
                end
                MON_RISE_OFS: begin
                    rise_q[wr_idx_m] <= merge(rise_q[wr_idx_m],
                                              w_data_q, w_strb_q);
                end
                default: begin
                    fall_q[wr_idx_m] <= merge(fall_q[wr_idx_m],
                                              w_data_q, w_strb_q);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int m = 0; m < NUM_MON; m++) begin
                t_rise_q[m] <= RISE_RST;
                t_fall_q[m] <= FALL_RST;
            end
        end else if (wr_fire && wr_trunk) begin
            if (aw_addr_q[2] == TRUNK_RISE_OFS) begin
                t_rise_q[wr_idx_t] <= merge(t_rise_q[wr_idx_t],
                                            w_data_q, w_strb_q); // see R18
            end else begin
                t_fall_q[wr_idx_t] <= merge(t_fall_q[wr_idx_t],
                                            w_data_q, w_strb_q);
            end
        end
    end

    // sticky event flags, write one to clear; a new event wins
    logic [31:0] evt_clr;
    assign evt_clr = (wr_fire && wr_evt)
                   ? merge(32'h0, w_data_q, w_strb_q) : 32'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_q <= '0;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | {fall_event_q, rise_event_q};
        end
    end

    // ------------
    // axi read channel
    // ------------
    logic [31:0] rd_data;
    logic        rd_hit;

    always_comb begin
        rd_data = 32'h0;
        rd_hit  = 1'b1;
        if (araddr[11:2] == ADDR_CTRL[11:2]) begin
            rd_data = {31'h0, trunk_q};
        end else if (araddr[11:2] == ADDR_EVT[11:2]) begin
            rd_data = evt_q;
        end else if (araddr[11:2] == ADDR_ARM[11:2]) begin
            rd_data = {16'h0, armed};
        end else if (araddr[11:5] == ADDR_CNT_BASE[11:5]) begin
            rd_data = cnt[araddr[4:2]]; // see R20
        end else if (araddr[11:8] == ADDR_MON_BASE[11:8]) begin
            case (araddr[3:2])
                MON_CTRL_OFS:   rd_data = {29'h0, mctrl_q[araddr[7:4]]};
                MON_PERIOD_OFS: rd_data = period_q[araddr[7:4]];
                MON_RISE_OFS:   rd_data = rise_q[araddr[7:4]];
                default:        rd_data = fall_q[araddr[7:4]];
            endcase
        end else if (araddr[11:7] == ADDR_TRUNK_BASE[11:7]) begin
            rd_data = araddr[2] ? t_fall_q[araddr[6:3]]
                                : t_rise_q[araddr[6:3]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign arready = ~rvalid;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_data;
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** gfp_error_stats_threshold_monitor_tb.sv ***
/* self-checking bench for the stats block.
   assumes a 20-clock second and the line source model. */
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    fail_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module gfp_error_stats_threshold_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gfp_stats_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, in_frame;
    logic [8:0] go = 9'h000;
    logic [7:0] pls;
    logic [NUM_MON-1:0] rise_event_q, fall_event_q;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    int fail_count = 0, checks_done = 0, cyc = 0;
    gfp_line_src u_gfp_line_src (.clk, .go, .pls, .in_frame);
    gfp_error_stats_threshold_monitor #(.SEC_CYCLES_P(20))
    u_gfp_error_stats_threshold_monitor (.clk, .rst_b,
        .rx_lcv_pulse(pls[0]), .tx_lcv_pulse(pls[1]),
        .fc_rx_lcv_pulse(pls[2]), .payload_crc_fail(pls[3]),
        .superblock_crc_fail(pls[4]), .csf_frame(pls[5]), .in_frame,
        .core_hdr_uncorr(pls[6]), .type_hdr_uncorr(pls[7]),
        .rise_event_q, .fall_event_q, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic fire(input int i, input int n);
        repeat (n) begin
            go[i] <= 1'b1;
            @(posedge clk);
            go[i] <= 1'b0;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        // late ready exercises the held answer
        bready <= 1'b1;
        @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_reset();
        rd(ADDR_MON_BASE + 12'h004);
        `CHK("period", PERIOD_RST, d);
        rd(ADDR_ARM);
        `CHK("armed", 32'h0000_FFFF, d);
        rd(12'h0FC);
        `CHK("unmapped", RESP_SLVERR, r);
        wr(12'h0FC, 32'h0);
        `CHK("bad wr", RESP_SLVERR, r);
    endtask
    task automatic t_count();
        int e [8] = '{4, 2, 4, 5, 6, 9, 7, 8};
        for (int i = 0; i < 9; i++) fire(i, i + 1);
        wr(ADDR_CNT_BASE, 32'h0);
        `CHK("ro wr", RESP_OKAY, r);
        for (int c = 0; c < 8; c++) begin
            rd(ADDR_CNT_BASE + 12'(4 * c));
            `CHK("counter", 32'(e[c]), d);
        end
    endtask
    task automatic t_abs();
        wr(ADDR_MON_BASE + 12'h048, 32'h5);
        wr(ADDR_MON_BASE + 12'h04C, 32'h2);
        wr(ADDR_MON_BASE + 12'h040, 32'h5);
        rd(ADDR_MON_BASE + 12'h058);
        `CHK("day rise", RISE_RST, d);
        wr(ADDR_EVT, 32'hFFFF_FFFF);
        fire(3, 1);
        rd(ADDR_EVT);
        `CHK("at thr", 32'h0, d & 32'h10);
        fire(3, 1);
        rd(ADDR_EVT);
        `CHK("above", 32'h10, d & 32'h10);
        wr(ADDR_EVT, 32'h10);
        fire(3, 1);
        rd(ADDR_EVT);
        `CHK("no refire", 32'h0, d & 32'h10);
    endtask
    task automatic t_rel();
        wr(ADDR_MON_BASE + 12'h030, 32'h3);
        wr(ADDR_MON_BASE + 12'h034, 32'h1);
        wr(ADDR_MON_BASE + 12'h038, 32'h1);
        wr(ADDR_MON_BASE + 12'h03C, 32'h1);
        // old traffic may fire once; quiet periods re-arm
        repeat (65) @(posedge clk);
        wr(ADDR_EVT, 32'hFFFF_FFFF);
        fire(1, 3);
        repeat (25) @(posedge clk);
        rd(ADDR_EVT);
        `CHK("rel rise", 32'h8, d & 32'h8);
        repeat (45) @(posedge clk);
        rd(ADDR_EVT);
        `CHK("rel fall", 32'h0008_0008, d & 32'h0008_0008);
        wr(ADDR_EVT, 32'h0008_0008);
        fire(1, 3);
        repeat (25) @(posedge clk);
        rd(ADDR_EVT);
        `CHK("rearmed", 32'h8, d & 32'h8);
    endtask
    task automatic t_trunk();
        wr(ADDR_TRUNK_BASE + 12'h030, 32'h1);
        wr(ADDR_TRUNK_BASE + 12'h034, 32'h0);
        wr(ADDR_MON_BASE + 12'h060, 32'h5);
        wr(ADDR_EVT, 32'hFFFF_FFFF);
        rd(ADDR_EVT);
        `CHK("client thr", 32'h0, d & 32'h40);
        wr(ADDR_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        rd(ADDR_EVT);
        `CHK("trunk thr", 32'h40, d & 32'h0010_0040);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_count();
        t_abs();
        t_rel();
        t_trunk();
        results();
    end
endmodule
bind gfp_error_stats_threshold_monitor gfp_stats_props u_gfp_stats_props (
    .clk, .rst_b, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rise_event_q,
    .fall_event_q);
`default_nettype wire

// *** gfp_line_src.sv ***
/* line-side source: event pulses and the in-frame level.
   assumes bench requests change just after an edge. */
`default_nettype none
module gfp_line_src (
    input  wire logic       clk,
    input  wire logic [8:0] go,
    output logic      [7:0] pls,
    output logic            in_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    // each low cycle is one exit from frame
    always_ff @(posedge clk) begin
        pls      <= go[7:0];
        in_frame <= !go[8];
    end
endmodule
`default_nettype wire

// *** gfp_stats_pkg.sv ***
/*
 * Shared constants of the GFP error statistics block:
 * offsets, field positions, reset values, timing counts.
 * Assumes a 125 MHz clock and an AXI4-Lite master.
 */
// Overview of operation
// R1 - count received 8b10b code violations on CBR
// R2 - count transmitted 8b10b code violations on CBR
// R3 - count received transparent frames failing payload CRC
// R4 - count every failing superblock CRC separately
// R5 - count client management frames with signal fail
// R6 - count each exit from the in-frame state
// R7 - count uncorrectable core header errors
// R8 - count uncorrectable type header errors separately
// R9 - alarm type: rising, falling or both
// R10 - relative mode compares occurrences in current period
// R11 - absolute mode compares cumulative total, ignoring period
// R12 - software programs period seconds and occurrence thresholds
// R13 - rising event needs passage from below falling
// R14 - dropping below falling re-arms the rising threshold
// R15 - only first rising crossing raises an event
// R16 - software should set falling below rising
// R17 - separate threshold sets for 15-minute and 1-day
// R18 - trunk port 9 has its own thresholds
// R19 - count low-rate fibre channel code violations too
// R20 - counters step by one per event, reads harmless
// R21 - relative count restarts each new sample period
`default_nettype none

package gfp_stats_pkg;

    // ------------
    // sizes
    // ------------
    localparam int ADDR_W  = 12;
    localparam int CNT_W   = 32;
    localparam int NUM_CNT = 8;
    localparam int NUM_MON = 16;

    // counter indices
    localparam int IDX_RX_LCV  = 0;
    localparam int IDX_TX_LCV  = 1;
    localparam int IDX_PL_CRC  = 2;
    localparam int IDX_SB_CRC  = 3;
    localparam int IDX_CSF     = 4;
    localparam int IDX_LFD     = 5;
    localparam int IDX_CHEC    = 6;
    localparam int IDX_THEC    = 7;

    // ------------
    // register map (byte addresses)
    // ------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_EVT        = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_ARM        = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_CNT_BASE   = 12'h040;
    localparam logic [ADDR_W-1:0] ADDR_MON_BASE   = 12'h100;
    localparam logic [ADDR_W-1:0] ADDR_TRUNK_BASE = 12'h200;

    // word within a monitor block (stride 0x10)
    localparam logic [1:0] MON_CTRL_OFS   = 2'h0;
    localparam logic [1:0] MON_PERIOD_OFS = 2'h1;
    localparam logic [1:0] MON_RISE_OFS   = 2'h2;
    localparam logic [1:0] MON_FALL_OFS   = 2'h3;
    // word within a trunk block (stride 0x08)
    localparam logic TRUNK_RISE_OFS = 1'h0;
    localparam logic TRUNK_FALL_OFS = 1'h1;

    // ------------
    // fields and encodings
    // ------------
    localparam int CTRL_TRUNK_BIT = 0;
    localparam int MCTRL_TYPE_LSB = 0;
    localparam int MCTRL_ABS_BIT  = 2;
    localparam int EVT_FALL_LSB   = 16;

    localparam logic [1:0] ALARM_RISING  = 2'h1;
    localparam logic [1:0] ALARM_FALLING = 2'h2;
    localparam logic [1:0] ALARM_BOTH    = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------
    // reset values
    // ------------
    localparam logic [2:0]       MCTRL_RST  = 3'h3;
    localparam logic [CNT_W-1:0] PERIOD_RST = 32'h0000_000F;
    localparam logic [CNT_W-1:0] RISE_RST   = 32'h0000_03E8;
    localparam logic [CNT_W-1:0] FALL_RST   = 32'h0000_0320;

    // ------------
    // timing
    // ------------
    localparam int SEC_NS        = 1000000000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// *** gfp_stats_props.sv ***
/* handshake and event pulse checks of the stats block.
   assumes binding into its top; one clock domain. */
`default_nettype none
module gfp_stats_props
    import gfp_stats_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               awvalid,
    input wire logic               awready,
    input wire logic               wvalid,
    input wire logic               wready,
    input wire logic               bvalid,
    input wire logic               bready,
    input wire logic [1:0]         bresp,
    input wire logic               arvalid,
    input wire logic               arready,
    input wire logic               rvalid,
    input wire logic               rready,
    input wire logic [31:0]        rdata,
    input wire logic [NUM_MON-1:0] rise_event_q,
    input wire logic [NUM_MON-1:0] fall_event_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_b_after_w: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("b late");
    chk_r_after_ar: assert property (
        arvalid && arready |=> rvalid) else $error("r late");
    chk_b_holds: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("b dropped");
    chk_r_holds: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("r dropped");
    chk_aw_blocked: assert property (
        bvalid |-> !awready && !wready) else $error("aw early");
    chk_ar_blocked: assert property (
        rvalid |-> !arready) else $error("ar early");
    chk_rise_once: assert property (
        rise_event_q != '0 |=> (rise_event_q & $past(rise_event_q)) == '0)
        else $error("rise twice");
    chk_fall_once: assert property (
        fall_event_q != '0 |=> (fall_event_q & $past(fall_event_q)) == '0)
        else $error("fall twice");
    chk_evt_excl: assert property (
        (rise_event_q & fall_event_q) == '0) else $error("both events");
    cov_rise: cover property (rise_event_q != '0);
    cov_fall: cover property (fall_event_q != '0);
    cov_stall: cover property (rvalid && !rready);
endmodule
`default_nettype wire

// *** threshold_monitor.sv ***
/*
 * One rising/falling threshold monitor with hysteresis.
 * Assumes a one-cycle seconds tick and a running total from a counter.
 */
`default_nettype none

module threshold_monitor
    import gfp_stats_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] total,
    input  wire logic [1:0]   inc,
    input  wire logic         sec_tick,
    input  wire logic [1:0]   alarm_type,
    input  wire logic         abs_mode,
    input  wire logic [W-1:0] period,
    input  wire logic [W-1:0] rise_thr,
    input  wire logic [W-1:0] fall_thr,
    output logic              rise_evt_q,
    output logic              fall_evt_q,
    output logic              rise_armed_q
);

    logic [W-1:0] sec_q;
    logic [W-1:0] acc_q;
    logic [W-1:0] last_sec;
    logic [W-1:0] value;
    logic         period_end;
    logic         sample;
    logic         fall_armed_q;

    // a zero period behaves as one second
    assign last_sec   = (period == '0) ? '0 : period - W'(1);
    assign period_end = sec_tick && (sec_q >= last_sec);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_q <= '0;
        end else if (period_end) begin
            sec_q <= '0;
        end else if (sec_tick) begin
            sec_q <= sec_q + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= '0;
        end else if (period_end) begin
            acc_q <= '0; // see R21
        end else begin
            acc_q <= acc_q + W'(inc);
        end
    end

    // relative: the finished period incl. this cycle's events
    assign value  = abs_mode ? total : acc_q + W'(inc); // see R10, R11
    assign sample = abs_mode | period_end; // see R11

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_armed_q <= 1'b1;
            fall_armed_q <= 1'b0;
            rise_evt_q   <= 1'b0;
            fall_evt_q   <= 1'b0;
        end else begin
            rise_evt_q <= 1'b0;
            fall_evt_q <= 1'b0;
            if (sample && value > rise_thr && rise_armed_q) begin
                // disarm so repeated exceedances stay quiet
                rise_armed_q <= 1'b0; // see R13, R15
                fall_armed_q <= 1'b1;
                rise_evt_q   <= alarm_type[0]; // see R9
            end else if (sample && value < fall_thr && fall_armed_q) begin
                rise_armed_q <= 1'b1; // see R14
                fall_armed_q <= 1'b0;
                fall_evt_q   <= alarm_type[1]; // see R9
            end
        end
    end

endmodule

`default_nettype wire
